/* File: inc/lovd_pkg.sv */
// Constants for the local overvoltage detector
// Assumes one 25 MHz system clock and a 12-bit sense sample stream
package lovd_pkg;

	// ***********************************************
	// Register map
	// ***********************************************
	localparam logic [7:0] LOVD_LIMIT_ADDR   = 8'h32;
	localparam logic [7:0] LOVD_LIMIT_RESET  = 8'h00;
	localparam int         LOVD_CODE_MSB     = 7;
	localparam int         LOVD_CODE_LSB     = 3;
	localparam int         LOVD_RSVD_BIT     = 2;
	localparam int         LOVD_CNT_MSB      = 1;
	localparam int         LOVD_CNT_LSB      = 0;

	// ***********************************************
	// Threshold arithmetic
	// ***********************************************
	localparam int         LOVD_ADC_W        = 12;
	localparam logic [6:0] LOVD_CODE_BASE    = 7'h59;
	localparam int         LOVD_DIV_SHIFT    = 7;
	localparam int         LOVD_ACC_W        = 24;

	// ***********************************************
	// Timing
	// ***********************************************
	localparam int         LOVD_CLK_MHZ      = 25;
	localparam int         LOVD_PERIOD_US    = 80;
	localparam int         LOVD_PERIOD_CYC   = LOVD_PERIOD_US * LOVD_CLK_MHZ;
	localparam int         LOVD_PCNT_W       = 12;

	typedef enum logic [1:0] {
		LOVD_IDLE  = 2'b00,
		LOVD_ACCUM = 2'b01,
		LOVD_JUDGE = 2'b10
	} lovd_state_e;

endpackage

/* File: core/lovd_run_counter.sv */
// Counts unbroken over-threshold periods and raises the fault flag
// Assumes one judge pulse per sampling period
`timescale 1ns/10ps
module lovd_run_counter
	import lovd_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	input  wire logic       judge,
	input  wire logic       over,
	input  wire logic [1:0] need_sel,
	output logic            fault_flag,
	output logic [2:0]      run_len
);

	logic [2:0] next_run;
	logic [2:0] need;
	logic       reached;

	// ***********************************************
	// Run length
	// ***********************************************
	assign need     = {1'b0, need_sel} + 3'h1;
	assign next_run = !judge ? run_len :
	                  !over ? 3'h0 :
	                  (run_len == 3'h4) ? run_len : run_len + 3'h1;
	assign reached  = judge && over && (next_run >= need);

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			run_len    <= 3'h0;
			fault_flag <= 1'b0;
		end else begin
			run_len    <= next_run;
			if (judge)
				fault_flag <= reached;
		end
	end

endmodule

/* File: core/lovd_top.sv */
// Local overvoltage detector: register, period averaging, threshold compare
// Assumes sense samples arrive with a valid strobe, scaled so full scale is 1.55 V
//
// Function
// - A five-bit limit code sets the limit, code zero at 107.7 percent, 1.21 percent per step.
// - Threshold equals (89 + code) / 128 of the 1.55 V full scale.
// - A period is over-threshold when its average sense voltage exceeds the threshold.
// - Each averaged comparison covers one 80 microsecond period.
// - With several samples required, the flag sets only if every required period was over.
// - The two-bit count field asks for one, two, three or four over-threshold periods.
`timescale 1ns/10ps
module lovd_top
	import lovd_pkg::*;
(
	input  wire logic                  clk_sys,
	input  wire logic                  sys_rst,
	input  wire logic [7:0]            reg_addr,
	input  wire logic                  reg_wr,
	input  wire logic [7:0]            reg_wdata,
	output logic      [7:0]            reg_rdata,
	input  wire logic                  sense_valid,
	input  wire logic [LOVD_ADC_W-1:0] local_sense_voltage,
	output logic                       overvoltage_fault_flag,
	output logic                       period_over,
	output logic                       period_done
);

	// ***********************************************
	// Configuration register
	// ***********************************************
	logic [7:0] local_overvoltage_limit;
	wire        sel_limit = (reg_addr == LOVD_LIMIT_ADDR);
	wire  [4:0] local_limit_code = local_overvoltage_limit[LOVD_CODE_MSB:LOVD_CODE_LSB];
	wire  [1:0] over_limit_sample_count = local_overvoltage_limit[LOVD_CNT_MSB:LOVD_CNT_LSB];
	wire  [7:0] next_rdata = sel_limit ? local_overvoltage_limit : 8'h00;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			local_overvoltage_limit <= LOVD_LIMIT_RESET;
			reg_rdata               <= 8'h00;
		end else begin
			if (reg_wr && sel_limit)
				local_overvoltage_limit <= reg_wdata;
			reg_rdata <= next_rdata;
		end
	end

	// ***********************************************
	// Threshold
	// ***********************************************
	// Full-scale ADC code stands for 1.55 V, so threshold = (89+code)*FS/128
	wire [6:0]  thr_num = LOVD_CODE_BASE + {2'b00, local_limit_code};
	wire [18:0] thr_prod = {12'h000, thr_num} * {7'h00, {LOVD_ADC_W{1'b1}}};
	wire [LOVD_ADC_W-1:0] thr_code = thr_prod[LOVD_DIV_SHIFT +: LOVD_ADC_W];

	// ***********************************************
	// Period averaging
	// ***********************************************
	lovd_state_e state;
	lovd_state_e next_state;
	logic [LOVD_PCNT_W-1:0] pcnt;
	logic [LOVD_ACC_W-1:0]  acc;
	logic [LOVD_PCNT_W-1:0] nsamp;
	logic                   judge;
	logic                   over;

	wire period_end = (pcnt == LOVD_PCNT_W'(LOVD_PERIOD_CYC - 1));
	wire [LOVD_ACC_W-1:0] thr_total = LOVD_ACC_W'({12'h000, thr_code} * {12'h000, nsamp});
	wire avg_over = (nsamp != '0) && (acc > thr_total);
	wire                   judge_now  = (state == LOVD_JUDGE);
	wire                   restart    = (state != LOVD_ACCUM);
	wire [LOVD_ACC_W-1:0]  acc_base   = restart ? '0 : acc;
	wire [LOVD_PCNT_W-1:0] nsamp_base = restart ? '0 : nsamp;
	wire [LOVD_ACC_W-1:0]  next_acc   = sense_valid ?
	                                    acc_base + LOVD_ACC_W'(local_sense_voltage) : acc_base;
	wire [LOVD_PCNT_W-1:0] next_nsamp = sense_valid ? nsamp_base + 1'b1 : nsamp_base;

	always_comb begin
		case (state)
			LOVD_IDLE:  next_state = LOVD_ACCUM;
			LOVD_ACCUM: next_state = period_end ? LOVD_JUDGE : LOVD_ACCUM;
			LOVD_JUDGE: next_state = LOVD_ACCUM;
			default:    next_state = LOVD_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state <= LOVD_IDLE;
			pcnt  <= '0;
			acc   <= '0;
			nsamp <= '0;
			judge <= 1'b0;
			over  <= 1'b0;
		end else begin
			state <= next_state;
			judge <= judge_now;
			if (judge_now)
				over <= avg_over;
			if (state != LOVD_IDLE && !period_end)
				pcnt <= pcnt + 1'b1;
			else
				pcnt <= '0;
			acc   <= next_acc;
			nsamp <= next_nsamp;
		end
	end

	// ***********************************************
	// Consecutive period count
	// ***********************************************
	lovd_run_counter u_run (
		.clk_sys    (clk_sys),
		.sys_rst    (sys_rst),
		.judge      (judge_now),
		.over       (avg_over),
		.need_sel   (over_limit_sample_count),
		.fault_flag (overvoltage_fault_flag),
		.run_len    ()
	);

	assign period_over = over;
	assign period_done = judge;

endmodule

/* File: tb/lovd_top_monitor.sv */
// Port checker for the local overvoltage detector
// Assumes it is bound to every lovd_top instance
`timescale 1ns/10ps
module lovd_top_monitor
	import lovd_pkg::*;
(
	input wire logic       clk_sys,
	input wire logic       sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic       reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic       period_done,
	input wire logic       period_over,
	input wire logic       overvoltage_fault_flag
);
	logic [11:0] gap;
	logic        seen;
	logic        prev;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	always_ff @(posedge clk_sys) begin
		gap  <= (sys_rst || period_done) ? 12'h000 : gap + 12'h001;
		seen <= !sys_rst && (seen || period_done);
		prev <= !sys_rst && (period_done ? period_over : prev);
	end
	chk_span_len: assert property (period_done && seen |-> gap == LOVD_PERIOD_CYC - 1)
		else $error("bad span");
	chk_done_pulse: assert property (period_done |=> !period_done)
		else $error("long done");
	chk_flag_hold: assert property (!period_done |-> $stable(overvoltage_fault_flag))
		else $error("flag moved");
	chk_flag_over: assert property (overvoltage_fault_flag |-> period_over)
		else $error("flag without over");
	chk_single_need: assert property (
		period_done && period_over && reg_rdata[1:0] == 2'b00
		&& $past(reg_addr) == LOVD_LIMIT_ADDR |-> overvoltage_fault_flag)
		else $error("flag missed");
	chk_run_prev: assert property (
		period_done && overvoltage_fault_flag && reg_rdata[1:0] != 2'b00
		&& $past(reg_addr) == LOVD_LIMIT_ADDR |-> prev)
		else $error("run broken");
	chk_reg_write: assert property (
		reg_wr && reg_addr == LOVD_LIMIT_ADDR ##1 reg_addr == LOVD_LIMIT_ADDR
		|=> reg_rdata == $past(reg_wdata, 2))
		else $error("write lost");
endmodule
bind lovd_top lovd_top_monitor lovd_top_monitor_i(.clk_sys, .sys_rst, .reg_addr, .reg_wr,
	.reg_wdata, .reg_rdata, .period_done, .period_over, .overvoltage_fault_flag);

/* File: tb/lovd_sense_model.sv */
// Sense converter model, quiet near period edges
// Assumes the bench changes level just after each judged period
`timescale 1ns/10ps
module lovd_sense_model
	import lovd_pkg::*;
(
	input  wire logic                  clk_sys,
	input  wire logic                  slow,
	input  wire logic                  period_done,
	input  wire logic [LOVD_ADC_W-1:0] level,
	output logic                       sense_valid,
	output logic      [LOVD_ADC_W-1:0] local_sense_voltage
);
	logic [11:0] age = 12'h000;
	logic        tog = 1'b0;
	always_ff @(posedge clk_sys) begin
		age <= period_done ? 12'h000 : age + 12'h001;
		tog <= ~tog;
	end
	assign sense_valid = age > 12'h004 && age < 12'h7c0 && (!slow || tog);
	assign local_sense_voltage = sense_valid ? level : ~level;
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the local overvoltage detector
// Assumes a 25 MHz clock and the sense model on the sample inputs
`timescale 1ns/10ps
module testbench
	import lovd_pkg::*;
;
	logic        clk_sys = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, slow = 1'b0;
	logic [7:0]  reg_addr = 8'h32, reg_wdata = 8'h00, reg_rdata;
	logic [11:0] level = 12'h000, sense;
	logic        valid, flag, over, done;
	logic [7:0]  q[$];
	int          failures = 0, check_count = 0, seed = 7, run;
	always #20 clk_sys = ~clk_sys;
	lovd_top lovd_top_i(.clk_sys, .sys_rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata,
		.sense_valid(valid), .local_sense_voltage(sense), .overvoltage_fault_flag(flag),
		.period_over(over), .period_done(done));
	lovd_sense_model lovd_sense_model_i(.clk_sys, .slow, .period_done(done), .level,
		.sense_valid(valid), .local_sense_voltage(sense));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic next_period;
		do @(posedge clk_sys); while (done !== 1'b1);
	endtask
	task automatic scen(input logic [4:0] code, input logic [1:0] need, input logic [7:0] pat,
		input int len);
		logic [11:0] thr;
		thr = 12'((int'(LOVD_CODE_BASE) + code) * 4095 >> LOVD_DIV_SHIFT);
		next_period();
		reg_wdata <= {code, 1'($random(seed)), need};
		reg_wr <= 1'b1;
		level <= thr;
		q.push_back(8'h00);
		run = 0;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk(reg_rdata, reg_wdata);
		reg_addr <= 8'h33;
		repeat (2) @(posedge clk_sys);
		chk(reg_rdata, 8'h00);
		reg_addr <= LOVD_LIMIT_ADDR;
		for (int i = 0; i < len; i++) begin
			next_period();
			level <= pat[i] ? thr + 12'h001 : thr;
			run = pat[i] ? run + 1 : 0;
			q.push_back({6'h00, pat[i], run > need});
		end
		$display("test with need %0d done", need);
	endtask
	always @(posedge clk_sys)
		if (done === 1'b1) chk({6'h00, over, flag}, q.size() ? q.pop_front() : 8'hxx);
	initial begin
		#(60000 * 40);
		failures++;
		report_and_stop();
	end
	initial begin
		q.push_back(8'h00);
		repeat (8) @(posedge clk_sys);
		sys_rst <= 1'b0;
		scen(5'h00, 2'b00, 8'h05, 3);
		scen(5'($random(seed)), 2'b01, 8'h1b, 5);
		scen(5'($random(seed)), 2'b10, 8'h07, 4);
		slow <= 1'b1;
		scen(5'h1f, 2'b11, 8'h1f, 5);
		next_period();
		@(posedge clk_sys);
		report_and_stop();
	end
endmodule
